/* File: logic/audio_route_pkg.sv */
// constants for the audio routing and playback converter control block
package audio_route_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_ROUTE_A = 8'h62;
  localparam logic [7:0] IDX_ROUTE_B = 8'h63;
  localparam logic [7:0] IDX_CONV_A = 8'h64;
  localparam logic [7:0] IDX_CONV_B = 8'h65;
  localparam logic [7:0] IDX_STATUS = 8'h7F;
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_ROUTE_A = {IDX_ROUTE_A, 2'b00};
  localparam logic [9:0] ADDR_ROUTE_B = {IDX_ROUTE_B, 2'b00};
  localparam logic [9:0] ADDR_CONV_A = {IDX_CONV_A, 2'b00};
  localparam logic [9:0] ADDR_CONV_B = {IDX_CONV_B, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  // reset values
  localparam logic [7:0] RST_ROUTE_A = 8'h00;
  localparam logic [7:0] RST_ROUTE_B = 8'h00;
  localparam logic [7:0] RST_CONV_A = 8'h00;
  localparam logic [7:0] RST_CONV_B = 8'h00;
  // writable bit masks; reserved bits read as zero
  localparam logic [7:0] MASK_ROUTE_B = 8'h3F;
  localparam logic [7:0] MASK_CONV_B = 8'h3F;
  // route_select_a fields
  localparam int RATE_SRC_LSB = 6;
  localparam int REC_SRC_LSB = 3;
  localparam int AUX_SRC_LSB = 0;
  // route_select_b fields
  localparam int DAC_SRC_LSB = 3;
  localparam int XMIT_SRC_LSB = 0;
  // playback_conv_control_a fields
  localparam int HARD_RESET_BIT = 7;
  localparam int LOGIC_RESET_BIT = 6;
  localparam int CHMAP_LSB = 4;
  localparam int INVERT_LSB = 2;
  localparam int RIGHT_SILENCE_N_BIT = 1;
  localparam int LEFT_SILENCE_N_BIT = 0;
  // playback_conv_control_b fields
  localparam int CLKDIV_LSB = 4;
  localparam int INTERP_LSB = 2;
  localparam int EMPH_LSB = 0;
  // source selector codes
  localparam logic [2:0] SRC_ADC = 3'h0;
  localparam logic [2:0] SRC_RECEIVER = 3'h1;
  localparam logic [2:0] SRC_PLAYBACK = 3'h2;
  localparam logic [2:0] SRC_AUX_IN = 3'h3;
  localparam logic [2:0] SRC_RATE_CONV = 3'h4;
  localparam int NUM_SRC = 5;
  // channel mapping codes
  localparam logic [1:0] MAP_NORMAL = 2'h0;
  localparam logic [1:0] MAP_BOTH_RIGHT = 2'h1;
  localparam logic [1:0] MAP_BOTH_LEFT = 2'h2;
  localparam logic [1:0] MAP_SWAPPED = 2'h3;
  // divider codes and their cycle periods minus one
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_1P5 = 2'h1;
  localparam logic [1:0] DIV_2 = 2'h2;
  localparam logic [1:0] DIV_3 = 2'h3;
  localparam logic [1:0] DIV_PERIOD_1 = 2'd0;
  localparam logic [1:0] DIV_PERIOD_2 = 2'd1;
  localparam logic [1:0] DIV_PERIOD_3 = 2'd2;
  // interpolation codes and converter ticks per sample
  localparam logic [1:0] INTERP_8X = 2'h0;
  localparam logic [1:0] INTERP_4X = 2'h1;
  localparam logic [1:0] INTERP_2X = 2'h2;
  localparam logic [3:0] TICKS_8X = 4'd8;
  localparam logic [3:0] TICKS_4X = 4'd4;
  localparam logic [3:0] TICKS_2X = 4'd2;
  // defaults of the datapath
  localparam int SAMPLE_W = 24;
  localparam int FIFO_DEPTH = 16;
endpackage : audio_route_pkg

/* File: logic/sample_fifo.sv */
// synchronous fifo with valid/ready on both sides
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // handshakes
  assign in_ready = (count_reg != DEPTH[PW:0]);
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];
  assign level = count_reg;

  // storage
  always_ff @(posedge clk)
  begin
    if (clk_en && push && !flush)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (clk_en)
    begin
      if (flush)
      begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg <= '0;
      end
      else
      begin
        if (push)
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        if (pop)
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
        if (push && !pop)
          count_reg <= count_reg + 1'b1;
        else if (pop && !push)
          count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : sample_fifo

/* File: logic/audio_route_ctrl.sv */
// routing selectors, playback converter controls and apb register file
// What this block does
// [RULE_01] A 2-bit selector picks adc, receiver, playback or aux in for the rate converter.
// [RULE_02] A 3-bit selector picks adc, receiver, playback, aux in or rate converter for record out.
// [RULE_03] A 3-bit selector with the same codes picks the aux output source.
// [RULE_04] A 3-bit selector in the second routing register picks the playback converter feed.
// [RULE_05] A 3-bit selector with the same codes picks the digital audio transmitter feed.
// [RULE_06] Hard reset bit set holds the converter in reset and power-down, outputs at ground.
// [RULE_07] Hard reset bit clear lets the converter run, outputs resting at reference level.
// [RULE_08] Logic reset bit set clears converter logic but keeps the control registers.
// [RULE_09] A 2-bit field maps channels: normal, both right, both left or swapped.
// [RULE_10] A 2-bit field inverts left, right, both or neither channel.
// [RULE_11] A 2-bit field sets interpolation 8x, 4x or 2x, code 11 reserved.
// [RULE_12] Each channel has an active-low silence bit, zero mutes that channel.
// [RULE_13] A 2-bit field divides the master clock by 1, 1.5, 2 or 3 for the converter.
// [RULE_14] A 2-bit field selects de-emphasis: none, 44.1, 32 or 48 kHz curve.
module audio_route_ctrl
  import audio_route_pkg::*;
#(
  parameter int W = audio_route_pkg::SAMPLE_W,
  parameter int DEPTH = audio_route_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [audio_route_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [W-1:0] adc_left,
  input wire logic [W-1:0] adc_right,
  input wire logic adc_valid,
  input wire logic [W-1:0] receiver_left,
  input wire logic [W-1:0] receiver_right,
  input wire logic receiver_valid,
  input wire logic [W-1:0] playback_left,
  input wire logic [W-1:0] playback_right,
  input wire logic playback_valid,
  input wire logic [W-1:0] aux_in_left,
  input wire logic [W-1:0] aux_in_right,
  input wire logic aux_in_valid,
  input wire logic [W-1:0] rate_conv_out_left,
  input wire logic [W-1:0] rate_conv_out_right,
  input wire logic rate_conv_out_valid,
  output logic [W-1:0] rate_converter_left,
  output logic [W-1:0] rate_converter_right,
  output logic rate_converter_valid,
  output logic [W-1:0] record_port_left,
  output logic [W-1:0] record_port_right,
  output logic record_port_valid,
  output logic [W-1:0] aux_out_left,
  output logic [W-1:0] aux_out_right,
  output logic aux_out_valid,
  output logic [W-1:0] transmitter_left,
  output logic [W-1:0] transmitter_right,
  output logic transmitter_valid,
  output logic dac_feed_ready,
  output logic [W-1:0] dac_left,
  output logic [W-1:0] dac_right,
  output logic dac_strobe,
  output logic dac_tick,
  output logic dac_powerdown,
  output logic dac_out_ground,
  output logic [1:0] interpolation_ratio,
  output logic [1:0] emphasis_filter_select
);
  import audio_route_pkg::*;
  localparam int FW = $clog2(DEPTH) + 1;
  logic [7:0] route_select_a_reg, route_select_b_reg;
  logic [7:0] playback_conv_control_a_reg, playback_conv_control_b_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic hit_next, hit_reg;
  logic [W-1:0] src_left [NUM_SRC];
  logic [W-1:0] src_right [NUM_SRC];
  logic src_valid [NUM_SRC];
  logic [2:0] sel_code [4];
  logic [2:0] dac_src;
  logic [W-1:0] route_left_reg [4];
  logic [W-1:0] route_right_reg [4];
  logic route_valid_reg [4];
  logic [W-1:0] dac_feed_left_reg, dac_feed_right_reg;
  logic dac_feed_valid_reg;
  logic hard_reset_powerdown, logic_reset_keep_regs, conv_hold;
  logic right_silence_n, left_silence_n;
  logic [1:0] channel_mapping, channel_inversion, converter_clock_divider;
  logic [1:0] div_cnt_reg, div_period;
  logic [3:0] interp_cnt_reg, ticks_per_sample;
  logic tick, sample_due, underrun_reg;
  logic fifo_out_valid, fifo_out_ready;
  logic [2*W-1:0] fifo_out_data;
  logic [FW-1:0] fifo_level;
  logic [W-1:0] map_left, map_right, proc_left, proc_right;
  // source index for a selector code; out-of-range codes mean no source
  function automatic logic [2:0] src_index(input logic [2:0] code);
    return (code <= SRC_RATE_CONV) ? code : 3'h7;
  endfunction : src_index
  // negate with saturation so the most negative code does not wrap
  function automatic logic [W-1:0] invert(input logic [W-1:0] x);
    return (x == {1'b1, {(W-1){1'b0}}}) ? {1'b0, {(W-1){1'b1}}} : W'(-x);
  endfunction : invert
  // field decode
  assign hard_reset_powerdown = playback_conv_control_a_reg[HARD_RESET_BIT];
  assign logic_reset_keep_regs = playback_conv_control_a_reg[LOGIC_RESET_BIT];
  assign channel_mapping = playback_conv_control_a_reg[CHMAP_LSB +: 2];
  assign channel_inversion = playback_conv_control_a_reg[INVERT_LSB +: 2];
  assign right_silence_n = playback_conv_control_a_reg[RIGHT_SILENCE_N_BIT];
  assign left_silence_n = playback_conv_control_a_reg[LEFT_SILENCE_N_BIT];
  assign converter_clock_divider = playback_conv_control_b_reg[CLKDIV_LSB +: 2];
  assign conv_hold = hard_reset_powerdown || logic_reset_keep_regs;

  // apb slave: zero wait, errors on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_reg;
  assign prdata = prdata_reg;

  // read mux, evaluated in the setup cycle
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    hit_next = 1'b1;
    case (paddr)
      ADDR_ROUTE_A: prdata_next[7:0] = route_select_a_reg;
      ADDR_ROUTE_B: prdata_next[7:0] = route_select_b_reg;
      ADDR_CONV_A: prdata_next[7:0] = playback_conv_control_a_reg;
      ADDR_CONV_B: prdata_next[7:0] = playback_conv_control_b_reg;
      ADDR_STATUS: prdata_next[FW+1:0] = {underrun_reg,
                                          !dac_feed_ready, fifo_level};
      default: hit_next = 1'b0;
    endcase
  end

  // read data and decode captured at setup, held through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      hit_reg <= 1'b0;
    end
    else if (clk_en && psel && !penable)
    begin
      prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
      hit_reg <= hit_next;
    end
  end

  // control registers; untouched by the converter logic reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      route_select_a_reg <= RST_ROUTE_A;
      route_select_b_reg <= RST_ROUTE_B;
      playback_conv_control_a_reg <= RST_CONV_A;
      playback_conv_control_b_reg <= RST_CONV_B;
    end
    else if (clk_en && psel && penable && pwrite)
    begin
      case (paddr)
        ADDR_ROUTE_A: route_select_a_reg <= pwdata[7:0];
        ADDR_ROUTE_B: route_select_b_reg <= pwdata[7:0] & MASK_ROUTE_B;
        ADDR_CONV_A: playback_conv_control_a_reg <= pwdata[7:0]; // see [RULE_08]
        ADDR_CONV_B: playback_conv_control_b_reg <= pwdata[7:0] & MASK_CONV_B;
        default: ;
      endcase
    end
  end

  // gather the five sources in selector-code order
  assign src_left = '{adc_left, receiver_left, playback_left, aux_in_left,
    rate_conv_out_left};
  assign src_right = '{adc_right, receiver_right, playback_right,
    aux_in_right, rate_conv_out_right};
  assign src_valid = '{adc_valid, receiver_valid, playback_valid,
    aux_in_valid, rate_conv_out_valid};
  // selector codes of the four routed outputs
  assign sel_code[0] = {1'b0, route_select_a_reg[RATE_SRC_LSB +: 2]}; // see [RULE_01]
  assign sel_code[1] = route_select_a_reg[REC_SRC_LSB +: 3]; // see [RULE_02]
  assign sel_code[2] = route_select_a_reg[AUX_SRC_LSB +: 3]; // see [RULE_03]
  assign sel_code[3] = route_select_b_reg[XMIT_SRC_LSB +: 3]; // see [RULE_05]
  assign dac_src = src_index(route_select_b_reg[DAC_SRC_LSB +: 3]);

  // one registered multiplexer per routed output
  for (genvar g = 0; g < 4; g++)
  begin : g_route
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        route_left_reg[g] <= '0;
        route_right_reg[g] <= '0;
        route_valid_reg[g] <= 1'b0;
      end
      else if (clk_en)
      begin
        if (src_index(sel_code[g]) < NUM_SRC)
        begin
          route_left_reg[g] <= src_left[src_index(sel_code[g])];
          route_right_reg[g] <= src_right[src_index(sel_code[g])];
          route_valid_reg[g] <= src_valid[src_index(sel_code[g])];
        end
        else
          route_valid_reg[g] <= 1'b0;
      end
    end
  end

  assign rate_converter_left = route_left_reg[0];
  assign rate_converter_right = route_right_reg[0];
  assign rate_converter_valid = route_valid_reg[0];
  assign record_port_left = route_left_reg[1];
  assign record_port_right = route_right_reg[1];
  assign record_port_valid = route_valid_reg[1];
  assign aux_out_left = route_left_reg[2];
  assign aux_out_right = route_right_reg[2];
  assign aux_out_valid = route_valid_reg[2];
  assign transmitter_left = route_left_reg[3];
  assign transmitter_right = route_right_reg[3];
  assign transmitter_valid = route_valid_reg[3];

  // playback converter feed, held off while the converter is in reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_feed_left_reg <= '0;
      dac_feed_right_reg <= '0;
      dac_feed_valid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (conv_hold || dac_src >= NUM_SRC)
        dac_feed_valid_reg <= 1'b0;
      else
      begin
        dac_feed_left_reg <= src_left[dac_src]; // see [RULE_04]
        dac_feed_right_reg <= src_right[dac_src];
        dac_feed_valid_reg <= src_valid[dac_src];
      end
    end
  end

  // sample buffer in front of the converter; flushed by either reset bit
  sample_fifo #(
    .WIDTH(2 * W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .clk_en(clk_en),
    .flush(conv_hold), // see [RULE_08]
    .in_valid(dac_feed_valid_reg),
    .in_ready(dac_feed_ready),
    .in_data({dac_feed_left_reg, dac_feed_right_reg}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // divider period in cycles minus one
  always_comb
  begin
    case (converter_clock_divider)
      DIV_1: div_period = DIV_PERIOD_1;
      DIV_2: div_period = DIV_PERIOD_2;
      default: div_period = DIV_PERIOD_3; // divide by 1.5 and by 3
    endcase
  end

  // /1.5 gives two ticks in every three cycles
  assign tick = !conv_hold && ((div_cnt_reg == 2'd0) ||
    (converter_clock_divider == DIV_1P5 && div_cnt_reg == 2'd1)); // see [RULE_13]
  assign dac_tick = tick;

  // converter clock divider counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_reg <= 2'd0;
    else if (clk_en)
    begin
      if (conv_hold || div_cnt_reg >= div_period)
        div_cnt_reg <= 2'd0;
      else
        div_cnt_reg <= div_cnt_reg + 2'd1;
    end
  end

  // converter ticks per input sample
  always_comb
  begin
    case (interpolation_ratio)
      INTERP_4X: ticks_per_sample = TICKS_4X;
      INTERP_2X: ticks_per_sample = TICKS_2X;
      default: ticks_per_sample = TICKS_8X; // 8x; reserved code runs as 8x
    endcase
  end

  assign interpolation_ratio = playback_conv_control_b_reg[INTERP_LSB +: 2]; // see [RULE_11]
  assign sample_due = tick && (interp_cnt_reg == 4'd0);
  assign fifo_out_ready = sample_due;

  // interpolation phase counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interp_cnt_reg <= 4'd0;
    else if (clk_en)
    begin
      if (conv_hold || (tick && interp_cnt_reg >= ticks_per_sample - 4'd1))
        interp_cnt_reg <= 4'd0;
      else if (tick)
        interp_cnt_reg <= interp_cnt_reg + 4'd1;
    end
  end

  // channel mapping: code bit 0 puts right data left, bit 1 left data right
  assign map_left = channel_mapping[0] ? fifo_out_data[W-1:0] :
    fifo_out_data[2*W-1:W]; // see [RULE_09]
  assign map_right = channel_mapping[1] ? fifo_out_data[2*W-1:W] :
    fifo_out_data[W-1:0]; // see [RULE_09]
  // polarity then mute; muted channel rests at mid-scale
  assign proc_left = !left_silence_n ? '0 :
    (channel_inversion[0] ? invert(map_left) : map_left); // see [RULE_10] [RULE_12]
  assign proc_right = !right_silence_n ? '0 :
    (channel_inversion[1] ? invert(map_right) : map_right); // see [RULE_10] [RULE_12]

  // converter samples and power state; zero code is the reference level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_left <= '0;
      dac_right <= '0;
      dac_strobe <= 1'b0;
      underrun_reg <= 1'b0;
      dac_powerdown <= 1'b0;
      dac_out_ground <= 1'b0;
      emphasis_filter_select <= 2'b00;
    end
    else if (clk_en)
    begin
      dac_powerdown <= hard_reset_powerdown; // see [RULE_06]
      dac_out_ground <= hard_reset_powerdown; // see [RULE_06] [RULE_07]
      emphasis_filter_select <=
        playback_conv_control_b_reg[EMPH_LSB +: 2]; // see [RULE_14]
      dac_strobe <= 1'b0;
      if (conv_hold)
      begin
        dac_left <= '0; // see [RULE_06] [RULE_08]
        dac_right <= '0;
        underrun_reg <= 1'b0;
      end
      else if (sample_due && fifo_out_valid)
      begin
        dac_left <= proc_left; // see [RULE_07]
        dac_right <= proc_right;
        dac_strobe <= 1'b1;
      end
      else if (sample_due)
        underrun_reg <= 1'b1;
    end
  end
endmodule : audio_route_ctrl

/* File: test/route_ctrl_asserts.sv */
// concurrent checks on the routing and playback control ports
module route_ctrl_asserts #(
  parameter int W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [audio_route_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [W-1:0] adc_left,
  input wire logic [W-1:0] rate_converter_left,
  input wire logic [W-1:0] dac_left,
  input wire logic dac_strobe,
  input wire logic dac_tick,
  input wire logic dac_out_ground,
  input wire logic [1:0] interpolation_ratio,
  input wire logic [1:0] emphasis_filter_select
);
  timeunit 1ns;
  timeprecision 100ps;
  import audio_route_pkg::*;
  logic [7:0] ra;
  logic [7:0] ca;
  logic [7:0] cb;
  logic wr;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // shadow copies of route_select_a and both converter control registers, taken at the access edge
  assign wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {ra, ca, cb} <= 24'h0;
    else if (wr && paddr == ADDR_ROUTE_A)
      ra <= pwdata[7:0];
    else if (wr && paddr == ADDR_CONV_A)
      ca <= pwdata[7:0];
    else if (wr && paddr == ADDR_CONV_B)
      cb <= pwdata[7:0];
  rate_feed_a: assert property (
    $past(presetn) && $past(ra[7:6]) == 2'h0
    |-> rate_converter_left == $past(adc_left)) else $error("rate feed");
  ground_flag_a: assert property (
    $past(presetn) |-> dac_out_ground == $past(ca[7])) else $error("ground");
  hard_quiet_a: assert property (
    ca[7] && $past(ca[7]) && $past(ca[7], 2) |-> ~|dac_left && !dac_strobe)
    else $error("active in hard reset");
  logic_quiet_a: assert property (
    ca[6] && $past(ca[6]) && $past(ca[6], 2) |-> !dac_tick && !dac_strobe)
    else $error("active in logic reset");
  mute_left_a: assert property (
    dac_strobe && !$past(ca[0]) && !$past(ca[0], 2) |-> ~|dac_left)
    else $error("left not silent");
  interp_field_a: assert property (
    interpolation_ratio == cb[3:2]) else $error("interpolation ratio");
  emph_field_a: assert property (
    $past(presetn) |-> emphasis_filter_select == $past(cb[1:0]))
    else $error("emphasis select");
  half_tick_a: assert property (
    dac_tick && cb[5:4] == 2'h2 |=> !dac_tick || cb[5:4] != 2'h2)
    else $error("divide by two ticked twice");
endmodule : route_ctrl_asserts
bind audio_route_ctrl route_ctrl_asserts #(.W(W)) route_ctrl_asserts_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .adc_left,
  .rate_converter_left, .dac_left, .dac_strobe, .dac_tick, .dac_out_ground,
  .interpolation_ratio, .emphasis_filter_select
);

/* File: test/testbench.sv */
// self-checking bench for the routing and playback control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import audio_route_pkg::*;
  typedef logic [SAMPLE_W-1:0] smp_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  smp_t sl [5] = '{default: 24'h0};
  smp_t sr [5] = '{default: 24'h0};
  logic [4:0] sv = 5'h0;
  wire smp_t ol [5];
  wire smp_t orr [5];
  wire dac_strobe;
  wire dac_tick;
  wire dac_powerdown;
  wire dac_out_ground;
  wire [1:0] interpolation_ratio;
  wire [1:0] emphasis_filter_select;
  int failures = 0;
  int n_compared = 0;
  smp_t q[$];
  logic [9:0] adr [4] = '{ADDR_ROUTE_A, ADDR_ROUTE_B, ADDR_CONV_A,
    ADDR_CONV_B};
  logic [7:0] msk [4] = '{8'hFF, MASK_ROUTE_B, 8'hFF, MASK_CONV_B};
  int tk [4] = '{12, 8, 6, 4};
  audio_route_ctrl audio_route_ctrl_i (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_left(sl[0]), .adc_right(sr[0]), .adc_valid(sv[0]),
    .receiver_left(sl[1]), .receiver_right(sr[1]), .receiver_valid(sv[1]),
    .playback_left(sl[2]), .playback_right(sr[2]), .playback_valid(sv[2]),
    .aux_in_left(sl[3]), .aux_in_right(sr[3]), .aux_in_valid(sv[3]),
    .rate_conv_out_left(sl[4]), .rate_conv_out_right(sr[4]),
    .rate_conv_out_valid(sv[4]), .rate_converter_left(ol[0]),
    .rate_converter_right(orr[0]), .rate_converter_valid(),
    .record_port_left(ol[1]), .record_port_right(orr[1]),
    .record_port_valid(), .aux_out_left(ol[2]), .aux_out_right(orr[2]),
    .aux_out_valid(), .transmitter_left(ol[3]), .transmitter_right(orr[3]),
    .transmitter_valid(), .dac_feed_ready(), .dac_left(ol[4]),
    .dac_right(orr[4]), .dac_strobe(dac_strobe), .dac_tick(dac_tick),
    .dac_powerdown(dac_powerdown), .dac_out_ground(dac_out_ground),
    .interpolation_ratio(interpolation_ratio),
    .emphasis_filter_select(emphasis_filter_select)
  );
  // clock
  always #2.5 pclk = ~pclk;
  // compares one result and records a mismatch
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // prints the counts and the verdict, then stops
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // a wait ran out: count it and close the run
  task automatic give_up();
    failures++;
    final_report();
  endtask : give_up
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      give_up();
  endtask : apb
  // waits a number of cycles and counts the cycles dac_tick, and unless tick_only also dac_strobe, was not low
  task automatic count(input int n, input logic tick_only, output int t);
    t = 0;
    repeat (n)
    begin
      @(posedge pclk);
      sv <= 5'h0;
      #1;
      t += (dac_tick !== 1'b0) + (!tick_only && dac_strobe !== 1'b0);
    end
  endtask : count
  // main sequence
  initial
  begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic err;
    smp_t x;
    smp_t y;
    int t;
    void'($urandom(32'h4511));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, adr[i], 32'h0, rd, err);
      chk("reset value", rd, 32'h0);
      wv = $urandom;
      apb(1'b1, adr[i], wv, rd, err);
      apb(1'b0, adr[i], 32'h0, rd, err);
      chk("read back", rd, {24'h0, wv[7:0] & msk[i]});
    end
    apb(1'b0, 10'h3F0, 32'h0, rd, err);
    chk("unmapped error", err, 1'b1);
    $display("test registers done");
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, ADDR_ROUTE_A, {k[1:0], k[2:0], k[2:0]}, rd, err);
      apb(1'b1, ADDR_ROUTE_B, {k[2:0], k[2:0]}, rd, err);
      repeat (3)
      begin
        @(posedge pclk);
        for (int j = 0; j < 5; j++)
        begin
          sl[j] <= $urandom;
          sr[j] <= $urandom;
        end
        sv <= 5'h1F;
        @(posedge pclk);
        #1;
        chk("rate feed", ol[0], sl[k % 4]);
        chk("record feed", orr[1], sr[k]);
        chk("aux feed", ol[2], sl[k]);
        chk("transmit feed", orr[3], sr[k]);
      end
    end
    count(1, 1'b1, t);
    apb(1'b1, ADDR_CONV_A, 32'h40, rd, err);
    apb(1'b0, ADDR_CONV_A, 32'h0, rd, err);
    chk("kept register", rd, 32'h40);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
    chk("flushed status", rd, 32'h0);
    $display("test routing done");
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, ADDR_ROUTE_B, {k[2:0], 3'h0}, rd, err);
      apb(1'b1, ADDR_CONV_A, {k[1:0], k[1:0], k < 4, k < 4}, rd, err);
      x = $urandom & 24'h7FFFFF;
      y = $urandom & 24'h7FFFFF;
      q.push_back(k == 4 ? 24'h0 : k[0] ? -y : x);
      q.push_back(k == 4 ? 24'h0 : k[1] ? -x : y);
      @(posedge pclk);
      sl[k] <= x;
      sr[k] <= y;
      sv[k] <= 1'b1;
      t = 0;
      do
      begin
        count(1, 1'b1, wv);
        t++;
      end
      while (dac_strobe !== 1'b1 && t < 300);
      if (t >= 300)
        give_up();
      chk("dac left", ol[4], q.pop_front());
      chk("dac right", orr[4], q.pop_front());
    end
    apb(1'b1, ADDR_CONV_A, 32'h83, rd, err);
    @(posedge pclk);
    sv[4] <= 1'b1;
    count(40, 1'b0, t);
    chk("activity", t, 0);
    chk("ground", dac_out_ground, 1'b1);
    chk("powerdown", dac_powerdown, 1'b1);
    chk("dac zero", ol[4], 24'h0);
    apb(1'b1, ADDR_CONV_A, 32'h03, rd, err);
    count(2, 1'b1, t);
    chk("ground off", dac_out_ground, 1'b0);
    $display("test converter done");
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, ADDR_CONV_B, {k[1:0], k[1:0], k[1:0]}, rd, err);
      count(2, 1'b1, t);
      count(12, 1'b1, t);
      chk("interp", interpolation_ratio, k[1:0]);
      chk("emphasis", emphasis_filter_select, k[1:0]);
      chk("ticks", t, tk[k]);
    end
    $display("test clocking done");
    final_report();
  end
  // watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge pclk);
    give_up();
  end
endmodule : testbench
